// ===== logic/tbs_pkg.sv
/*
  Package of the terminal bus supervisor: register map, field layouts,
  reset values, states and timing constants.
  Assumes a 200 MHz clock and a simple strobe register port.
*/
`default_nettype none
package tbs_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned RETRIG_MS = 85;
  localparam int unsigned BASE_MS = 100;
  localparam int unsigned MS_CYCLES = CLK_MHZ * 1000;
  localparam int unsigned RETRIG_CYCLES = RETRIG_MS * MS_CYCLES;
  localparam int unsigned BASE_CYCLES = BASE_MS * MS_CYCLES;
  localparam int unsigned US_CYCLES = CLK_MHZ;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TASK_CUR = 8'h10;
  localparam logic [7:0] ADDR_TASK_MAX = 8'h14;
  localparam logic [7:0] ADDR_TBUS_CUR = 8'h18;
  localparam logic [7:0] ADDR_TBUS_MAX = 8'h1C;
  localparam logic [7:0] ADDR_FBUS_CUR = 8'h20;
  localparam logic [7:0] ADDR_FBUS_MAX = 8'h24;
  localparam logic [7:0] ADDR_SSB_CUR = 8'h28;
  localparam logic [7:0] ADDR_SSB_MAX = 8'h2C;

  localparam int unsigned CTRL_CHECK = 0;
  localparam int unsigned CTRL_AUTORST = 1;
  localparam int unsigned CTRL_CLRBRK = 2;
  localparam int unsigned CTRL_SYNCFB = 3;
  localparam int unsigned CTRL_INZERO = 4;
  localparam int unsigned CTRL_OUTZERO = 5;
  localparam int unsigned CTRL_RETRIG_LO = 6;
  localparam logic [7:0] CTRL_DEFAULT = 8'hC2;

  localparam int unsigned CMD_SAVE_REF = 0;
  localparam int unsigned CMD_RST_MAX = 1;
  localparam int unsigned CMD_FACTORY = 2;
  localparam int unsigned CMD_BUS_RST = 3;

  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [1:0] RETRIG_ZERO = 2'h0;

  typedef enum logic [1:0] {
    TBS_CHECK = 2'b00,
    TBS_RUN = 2'b01,
    TBS_FAULT = 2'b10,
    TBS_HALT = 2'b11
  } tbs_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tbs_reg_req_t;
endpackage : tbs_pkg
`default_nettype wire

// ===== logic/tbs_cycle_meter.sv
/*
  Cycle-time meter: counts microseconds between start and stop pulses,
  keeps current and maximum values.
  Assumes start and stop are one-cycle pulses on the system clock.
*/
`default_nettype none
module tbs_cycle_meter (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_clr_max,
  output logic [15:0] o_cur,
  output logic [15:0] o_max
);
  logic [7:0] pre_ff;
  logic [15:0] cnt_ff;
  logic run_ff;
  logic us_tick;

  assign us_tick = (pre_ff == 8'(tbs_pkg::US_CYCLES - 1));

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      pre_ff <= 8'h00;
      cnt_ff <= tbs_pkg::ZERO16;
      run_ff <= 1'b0;
    end
    else if (i_start)
    begin
      pre_ff <= 8'h00;
      cnt_ff <= tbs_pkg::ZERO16;
      run_ff <= 1'b1;
    end
    else if (i_stop)
      run_ff <= 1'b0;
    else if (run_ff)
    begin
      pre_ff <= us_tick ? 8'h00 : pre_ff + 8'h01;
      if (us_tick && cnt_ff != 16'hFFFF)
        cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      o_cur <= tbs_pkg::ZERO16;
    else if (i_stop && run_ff)
      o_cur <= cnt_ff;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      o_max <= tbs_pkg::ZERO16;
    else if (i_stop && run_ff && cnt_ff > o_max)
      o_max <= cnt_ff;
    else if (i_clr_max)
      o_max <= tbs_pkg::ZERO16;
  end
endmodule : tbs_cycle_meter
`default_nettype wire

// ===== logic/tbs_supervisor.sv
/*
  Terminal bus supervisor: start-up check, fault recovery, breakpoint
  clearing, sync source, watchdog re-trigger, input and output reaction,
  cycle diagnostics, register port.
  Assumes all inputs synchronous to I_CLK; events are one-cycle pulses.
*/
// Chosen here: strobed register access and the placing of the registers.
`default_nettype none
// How it works
// - A save command stores the present terminal arrangement as reference.
// - After each restart the attached arrangement is compared with the reference.
// - With the check enabled and a mismatch, exchange and program start are held off.
// - With auto recovery enabled, exchange restarts by itself once the fault clears.
// - On recovery the outputs carry current values at once, with no extra step.
// - With clear-on-breakpoint enabled, a halted program stops bus service.
// - Bus cycles are triggered by task 1 or by the fieldbus cycle, as selected.
// - If the bus goes unserviced past the watchdog window, outputs drop.
// - By default the watchdog is re-triggered every 85 ms up to three times.
// - The re-trigger setting picks a window of 100, 170, 255 or 340 ms.
// - On a bus fault the input image is forced to zero or frozen, as selected.
// - On program stop fieldbus outputs are cleared or kept, as selected.
// - Cycle times of task 1, bus, fieldbus and system bus load are measured.
// - A reset-maxima command clears all maxima, except one that a stop pulse raises in the same cycle.
// - A factory request restores defaults, taking effect at next restart.
module tbs_supervisor #(
  parameter int unsigned RETRIG_CYC = tbs_pkg::RETRIG_CYCLES,
  parameter int unsigned BASE_CYC = tbs_pkg::BASE_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic [15:0] I_TERM_CFG,
  input wire logic I_BUS_FAULT,
  input wire logic I_TASK1_START,
  input wire logic I_TASK1_END,
  input wire logic I_FBUS_START,
  input wire logic I_FBUS_END,
  input wire logic I_SSB_START,
  input wire logic I_SSB_END,
  input wire logic I_BUS_DONE,
  input wire logic I_PLC_RUN,
  input wire logic I_BREAKPOINT,
  input wire logic I_CPU_BUSY,
  input wire logic [31:0] I_TERM_IN,
  input wire logic [31:0] I_PLC_OUT,
  output logic [31:0] O_IN_IMAGE,
  output logic [31:0] O_FBUS_OUT,
  output logic [31:0] O_TERM_OUT,
  output logic O_BUS_CYCLE,
  output logic O_PLC_ENABLE,
  output logic O_OUT_ENABLE,
  output logic O_WDOG_EXPIRED
);
  tbs_pkg::tbs_state_t state_ff;
  tbs_pkg::tbs_reg_req_t req;
  logic [7:0] ctrl_ff;
  logic [7:0] ctrl_live_ff;
  logic [15:0] ref_cfg_ff;
  logic check_fail_ff;
  logic [31:0] wd_cnt_ff;
  logic [1:0] retrig_ff;
  logic wd_exp_ff;
  logic cmd_save;
  logic cmd_rst_max;
  logic cmd_factory;
  logic cmd_bus_rst;
  logic sync_evt;
  logic servicing;
  logic tbus_start;
  logic [15:0] task_cur, task_max, tbus_cur, tbus_max;
  logic [15:0] fbus_cur, fbus_max, ssb_cur, ssb_max;

  function automatic logic [31:0] pack2(input logic [15:0] v);
    pack2 = {tbs_pkg::ZERO16, v};
  endfunction : pack2

  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  assign cmd_save = req.wr && req.addr == tbs_pkg::ADDR_CMD && req.wdata[tbs_pkg::CMD_SAVE_REF];
  assign cmd_rst_max = req.wr && req.addr == tbs_pkg::ADDR_CMD && req.wdata[tbs_pkg::CMD_RST_MAX];
  assign cmd_factory = req.wr && req.addr == tbs_pkg::ADDR_CMD && req.wdata[tbs_pkg::CMD_FACTORY];
  assign cmd_bus_rst = req.wr && req.addr == tbs_pkg::ADDR_CMD && req.wdata[tbs_pkg::CMD_BUS_RST];

  // Stored settings, live settings latched at restart
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      ctrl_ff <= tbs_pkg::CTRL_DEFAULT;
    else if (cmd_factory)
      ctrl_ff <= tbs_pkg::CTRL_DEFAULT;
    else if (req.wr && req.addr == tbs_pkg::ADDR_CTRL)
      ctrl_ff <= req.wdata[7:0];
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      ctrl_live_ff <= tbs_pkg::CTRL_DEFAULT;
    else if (state_ff == tbs_pkg::TBS_CHECK)
      ctrl_live_ff <= ctrl_ff;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      ref_cfg_ff <= tbs_pkg::ZERO16;
    else if (cmd_save)
      ref_cfg_ff <= I_TERM_CFG;
  end

  // Main state
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      state_ff <= tbs_pkg::TBS_CHECK;
      check_fail_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        tbs_pkg::TBS_CHECK:
        begin
          check_fail_ff <= (I_TERM_CFG != ref_cfg_ff);
          if (ctrl_ff[tbs_pkg::CTRL_CHECK] && I_TERM_CFG != ref_cfg_ff)
            state_ff <= tbs_pkg::TBS_HALT;
          else
            state_ff <= tbs_pkg::TBS_RUN;
        end
        tbs_pkg::TBS_RUN:
          if (I_BUS_FAULT || wd_exp_ff)
            state_ff <= tbs_pkg::TBS_FAULT;
        tbs_pkg::TBS_FAULT:
          if (!I_BUS_FAULT && (ctrl_live_ff[tbs_pkg::CTRL_AUTORST] || cmd_bus_rst))
            state_ff <= tbs_pkg::TBS_RUN;
        tbs_pkg::TBS_HALT:
          state_ff <= tbs_pkg::TBS_HALT;
        default:
          state_ff <= tbs_pkg::TBS_CHECK;
      endcase
    end
  end

  // Bus service and sync source
  assign servicing = state_ff == tbs_pkg::TBS_RUN &&
    !(ctrl_live_ff[tbs_pkg::CTRL_CLRBRK] && I_BREAKPOINT);
  assign sync_evt = ctrl_live_ff[tbs_pkg::CTRL_SYNCFB] ? I_FBUS_START : I_TASK1_START;
  assign tbus_start = servicing && sync_evt && !I_CPU_BUSY;

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_BUS_CYCLE <= 1'b0;
    else
      O_BUS_CYCLE <= tbus_start;
  end

  // Watchdog with re-triggers
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      wd_cnt_ff <= tbs_pkg::ZERO32;
      retrig_ff <= tbs_pkg::RETRIG_ZERO;
      wd_exp_ff <= 1'b0;
    end
    else if (tbus_start || state_ff != tbs_pkg::TBS_RUN)
    begin
      wd_cnt_ff <= tbs_pkg::ZERO32;
      retrig_ff <= tbs_pkg::RETRIG_ZERO;
      wd_exp_ff <= 1'b0;
    end
    else if (!wd_exp_ff)
    begin
      if (ctrl_live_ff[7:6] == tbs_pkg::RETRIG_ZERO)
      begin
        if (wd_cnt_ff == 32'(BASE_CYC - 1))
          wd_exp_ff <= 1'b1;
        else
          wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
      end
      else if (wd_cnt_ff == 32'(RETRIG_CYC - 1))
      begin
        wd_cnt_ff <= tbs_pkg::ZERO32;
        if (retrig_ff == ctrl_live_ff[7:6])
          wd_exp_ff <= 1'b1;
        else
          retrig_ff <= retrig_ff + 2'h1;
      end
      else
        wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
    end
  end

  // Data images
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_TERM_OUT <= tbs_pkg::ZERO32;
    else if (!servicing || wd_exp_ff)
      O_TERM_OUT <= tbs_pkg::ZERO32;
    else
      O_TERM_OUT <= I_PLC_OUT;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_IN_IMAGE <= tbs_pkg::ZERO32;
    else if (state_ff == tbs_pkg::TBS_FAULT)
    begin
      if (ctrl_live_ff[tbs_pkg::CTRL_INZERO])
        O_IN_IMAGE <= tbs_pkg::ZERO32;
    end
    else if (I_BUS_DONE && servicing)
      O_IN_IMAGE <= I_TERM_IN;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_FBUS_OUT <= tbs_pkg::ZERO32;
    else if (!I_PLC_RUN)
    begin
      if (ctrl_live_ff[tbs_pkg::CTRL_OUTZERO])
        O_FBUS_OUT <= tbs_pkg::ZERO32;
    end
    else
      O_FBUS_OUT <= I_PLC_OUT;
  end

  assign O_PLC_ENABLE = state_ff != tbs_pkg::TBS_HALT && state_ff != tbs_pkg::TBS_CHECK;
  assign O_OUT_ENABLE = servicing && !wd_exp_ff;
  assign O_WDOG_EXPIRED = wd_exp_ff;

  // Cycle diagnostics
  tbs_cycle_meter u_task (.I_CLK(I_CLK), .I_NRST(I_NRST), .i_start(I_TASK1_START),
    .i_stop(I_TASK1_END), .i_clr_max(cmd_rst_max), .o_cur(task_cur), .o_max(task_max));
  tbs_cycle_meter u_tbus (.I_CLK(I_CLK), .I_NRST(I_NRST), .i_start(tbus_start),
    .i_stop(I_BUS_DONE), .i_clr_max(cmd_rst_max), .o_cur(tbus_cur), .o_max(tbus_max));
  tbs_cycle_meter u_fbus (.I_CLK(I_CLK), .I_NRST(I_NRST), .i_start(I_FBUS_START),
    .i_stop(I_FBUS_END), .i_clr_max(cmd_rst_max), .o_cur(fbus_cur), .o_max(fbus_max));
  tbs_cycle_meter u_ssb (.I_CLK(I_CLK), .I_NRST(I_NRST), .i_start(I_SSB_START),
    .i_stop(I_SSB_END), .i_clr_max(cmd_rst_max), .o_cur(ssb_cur), .o_max(ssb_max));

  // Register read port
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_RDATA <= tbs_pkg::ZERO32;
    else if (req.rd)
    begin
      case (req.addr)
        tbs_pkg::ADDR_CTRL: O_RDATA <= {24'h00_0000, ctrl_ff};
        tbs_pkg::ADDR_STATUS: O_RDATA <= {26'h000_0000, retrig_ff, wd_exp_ff,
          check_fail_ff, state_ff};
        tbs_pkg::ADDR_TASK_CUR: O_RDATA <= pack2(task_cur);
        tbs_pkg::ADDR_TASK_MAX: O_RDATA <= pack2(task_max);
        tbs_pkg::ADDR_TBUS_CUR: O_RDATA <= pack2(tbus_cur);
        tbs_pkg::ADDR_TBUS_MAX: O_RDATA <= pack2(tbus_max);
        tbs_pkg::ADDR_FBUS_CUR: O_RDATA <= pack2(fbus_cur);
        tbs_pkg::ADDR_FBUS_MAX: O_RDATA <= pack2(fbus_max);
        tbs_pkg::ADDR_SSB_CUR: O_RDATA <= pack2(ssb_cur);
        tbs_pkg::ADDR_SSB_MAX: O_RDATA <= pack2(ssb_max);
        default: O_RDATA <= tbs_pkg::ZERO32;
      endcase
    end
    else
      O_RDATA <= tbs_pkg::ZERO32;
  end
endmodule : tbs_supervisor
`default_nettype wire

// ===== bench/tbs_term_chain.sv
/*
  Terminal chain model: answers each bus cycle after DLY clocks.
  Assumes one-cycle bus cycle pulses from the supervisor.
*/
`default_nettype none
module tbs_term_chain #(
  parameter int DLY = 5
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cycle,
  input wire logic i_fault,
  input wire logic i_expired,
  input wire logic [31:0] i_out,
  output logic o_done,
  output logic [31:0] o_in,
  output logic [31:0] o_latch
);
  int cnt_ff;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_ff <= 0;
      o_done <= 1'b0;
      o_in <= 32'h0000_0000;
    end
    else
    begin
      o_done <= (cnt_ff == 1);
      cnt_ff <= i_cycle ? DLY : (cnt_ff > 0 ? cnt_ff - 1 : 0);
      if (i_fault)
        o_in <= ~o_in;
      else if (cnt_ff == 1)
        o_in <= o_in + 32'h0101_0101;
    end
  end
  // Outputs drop once the watchdog runs out
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_latch <= 32'h0000_0000;
    else if (i_expired)
      o_latch <= 32'h0000_0000;
    else if (cnt_ff == 1)
      o_latch <= i_out;
  end
endmodule : tbs_term_chain
`default_nettype wire

// ===== bench/tbs_supervisor_properties.sv
/*
  Checker on the supervisor ports.
  Assumes the bind below and a single clock domain.
*/
`default_nettype none
module tbs_supervisor_properties #(
  parameter int unsigned RETRIG_CYC = 50,
  parameter int unsigned BASE_CYC = 60
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [7:0] I_ADDR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic I_TASK1_START,
  input wire logic I_FBUS_START,
  input wire logic I_CPU_BUSY,
  input wire logic I_BUS_FAULT,
  input wire logic I_BUS_DONE,
  input wire logic [31:0] I_TERM_IN,
  input wire logic [31:0] O_IN_IMAGE,
  input wire logic [31:0] O_TERM_OUT,
  input wire logic O_BUS_CYCLE,
  input wire logic O_WDOG_EXPIRED
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  int unsigned idle_ff;
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      idle_ff <= 0;
    else
      idle_ff <= (O_BUS_CYCLE || O_WDOG_EXPIRED) ? 0 : idle_ff + 1;
  end
  sequence s_fault_held;
    $past(I_BUS_FAULT, 2) && $past(I_BUS_FAULT) && I_BUS_FAULT;
  endsequence
  sequence s_done_ok;
    I_BUS_DONE && !I_BUS_FAULT && !O_WDOG_EXPIRED;
  endsequence
  a_rdata_quiet: assert property (!$past(I_RD) |-> O_RDATA == 32'h0000_0000)
    else $error("read data outside read answer");
  a_unmapped_zero: assert property (I_RD && I_ADDR == 8'h30 |=> O_RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_cycle_cause: assert property (O_BUS_CYCLE |-> $past(I_TASK1_START || I_FBUS_START))
    else $error("bus cycle without sync pulse");
  a_busy_blocks: assert property (O_BUS_CYCLE |-> !$past(I_CPU_BUSY))
    else $error("bus cycle while cpu busy");
  a_expired_zero: assert property ($rose(O_WDOG_EXPIRED) |=> O_TERM_OUT == 32'h0000_0000)
    else $error("outputs live after expiry");
  a_wdog_window: assert property ($rose(O_WDOG_EXPIRED) |->
    idle_ff >= RETRIG_CYC && idle_ff <= BASE_CYC + 4 * RETRIG_CYC)
    else $error("watchdog window wrong");
  a_image_frozen: assert property (s_fault_held |-> $stable(O_IN_IMAGE))
    else $error("input image moved during fault");
  a_image_load: assert property (s_done_ok |=> O_IN_IMAGE == $past(I_TERM_IN))
    else $error("input image not loaded");
endmodule : tbs_supervisor_properties
bind tbs_supervisor tbs_supervisor_properties #(.RETRIG_CYC(RETRIG_CYC), .BASE_CYC(BASE_CYC))
  i_tbs_supervisor_properties (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_RD(I_RD),
  .O_RDATA(O_RDATA), .I_TASK1_START(I_TASK1_START), .I_FBUS_START(I_FBUS_START),
  .I_CPU_BUSY(I_CPU_BUSY), .I_BUS_FAULT(I_BUS_FAULT), .I_BUS_DONE(I_BUS_DONE),
  .I_TERM_IN(I_TERM_IN), .O_IN_IMAGE(O_IN_IMAGE), .O_TERM_OUT(O_TERM_OUT),
  .O_BUS_CYCLE(O_BUS_CYCLE), .O_WDOG_EXPIRED(O_WDOG_EXPIRED));
`default_nettype wire

// ===== bench/tb_tbs_supervisor.sv
/*
  Self-checking bench of the supervisor with the terminal chain model.
  Assumes default settings; short watchdog parameters.
*/
`default_nettype none
module tb_tbs_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RC = 50;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, fault = 0, t1s = 0, t1e = 0, fbs = 0;
  logic fbe = 0, run = 1, busy = 0, cyc, done, plc_en, out_en, wdx;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, pout = 32'h1234_5678, rdata, img, fout, tout;
  logic [31:0] tin, tlat, d;
  int error_cnt = 0, compares = 0, tick = 0, n;
  tbs_supervisor #(.RETRIG_CYC(RC), .BASE_CYC(60)) i_tbs_supervisor (.I_CLK(clk),
    .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_TERM_CFG(16'h0011), .I_BUS_FAULT(fault), .I_TASK1_START(t1s), .I_TASK1_END(t1e),
    .I_FBUS_START(fbs), .I_FBUS_END(fbe), .I_SSB_START(1'b0), .I_SSB_END(1'b0),
    .I_BUS_DONE(done), .I_PLC_RUN(run), .I_BREAKPOINT(1'b0), .I_CPU_BUSY(busy),
    .I_TERM_IN(tin), .I_PLC_OUT(pout), .O_IN_IMAGE(img), .O_FBUS_OUT(fout),
    .O_TERM_OUT(tout), .O_BUS_CYCLE(cyc), .O_PLC_ENABLE(plc_en), .O_OUT_ENABLE(out_en),
    .O_WDOG_EXPIRED(wdx));
  tbs_term_chain i_tbs_term_chain (.i_clk(clk), .i_nrst(nrst), .i_cycle(cyc),
    .i_fault(fault), .i_expired(wdx), .i_out(tout), .o_done(done), .o_in(tin),
    .o_latch(tlat));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task print_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [7:0] a);
    @(posedge clk) addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task sync1;
    @(posedge clk) t1s <= 1'b1;
    @(posedge clk) t1s <= 1'b0;
    #1;
  endtask : sync1
  task wdone;
    for (int k = 0; k < 40 && done !== 1'b1; k++)
      @(posedge clk) #1;
    @(posedge clk) #1;
  endtask : wdone
  task t_regs;
    rreg(tbs_pkg::ADDR_CTRL);
    chk(d, {24'h00_0000, tbs_pkg::CTRL_DEFAULT});
    rreg(8'h30);
    chk(d, 32'h0000_0000);
    rreg(tbs_pkg::ADDR_STATUS);
    chk({30'h0, d[1:0]}, 32'h0000_0001);
    $display("test regs done");
  endtask : t_regs
  task t_sync;
    @(posedge clk) fbs <= 1'b1;
    @(posedge clk) fbs <= 1'b0;
    #1 chk({31'h0, cyc}, 32'h0000_0000);
    busy <= 1'b1;
    sync1();
    chk({31'h0, cyc}, 32'h0000_0000);
    busy <= 1'b0;
    sync1();
    chk({31'h0, cyc}, 32'h0000_0001);
    wdone();
    chk(img, tin);
    chk(tlat, pout);
    $display("test sync done");
  endtask : t_sync
  task t_wdog;
    sync1();
    for (n = 0; n < 400 && wdx !== 1'b1; n++)
      @(posedge clk) #1;
    chk({31'h0, n >= 4 * RC - 2 && n <= 4 * RC + 2}, 32'h0000_0001);
    @(posedge clk) #1;
    chk(tout, 32'h0000_0000);
    chk(tlat, 32'h0000_0000);
    $display("test watchdog done");
  endtask : t_wdog
  task t_fault;
    logic [31:0] held;
    @(posedge clk) fault <= 1'b1;
    repeat (3) @(posedge clk);
    #1 held = img;
    sync1();
    repeat (10) @(posedge clk);
    #1 chk(img, held);
    @(posedge clk) fault <= 1'b0;
    pout <= 32'hA5A5_0F0F;
    repeat (4) @(posedge clk);
    sync1();
    chk({31'h0, cyc}, 32'h0000_0001);
    wdone();
    chk(tlat, 32'hA5A5_0F0F);
    chk({31'h0, wdx}, 32'h0000_0000);
    $display("test fault done");
  endtask : t_fault
  task t_meter;
    @(posedge clk) t1s <= 1'b1;
    @(posedge clk) t1s <= 1'b0;
    repeat (2 * tbs_pkg::US_CYCLES) @(posedge clk);
    t1e <= 1'b1;
    @(posedge clk) t1e <= 1'b0;
    rreg(tbs_pkg::ADDR_TASK_CUR);
    chk({31'h0, d >= 1 && d <= 2}, 32'h0000_0001);
    n = d;
    rreg(tbs_pkg::ADDR_TASK_MAX);
    chk(d, n);
    wreg(tbs_pkg::ADDR_CMD, 32'h0000_0002);
    rreg(tbs_pkg::ADDR_TASK_MAX);
    chk(d, 32'h0000_0000);
    $display("test meter done");
  endtask : t_meter
  task t_stop;
    logic [31:0] kept;
    @(posedge clk) fbs <= 1'b1;
    @(posedge clk) fbs <= 1'b0;
    fbe <= 1'b1;
    @(posedge clk) fbe <= 1'b0;
    repeat (3) @(posedge clk);
    #1 kept = fout;
    chk(fout, pout);
    @(posedge clk) run <= 1'b0;
    pout <= 32'h0BAD_F00D;
    repeat (5) @(posedge clk);
    #1 chk(fout, kept);
    $display("test stop done");
  endtask : t_stop
  always @(posedge clk)
  begin
    tick++;
    if (tick == 6000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_sync();
    t_wdog();
    t_fault();
    t_meter();
    t_stop();
    print_verdict();
  end
endmodule : tb_tbs_supervisor
`default_nettype wire
